// *** rtl/i2ccfg_pkg.sv ***
// package: register map, field layouts and timing for the serial bus configuration block
package i2ccfg_pkg;
  // register byte offsets (12-bit window)
  localparam logic [11:0] HWGC_ID_OFF = 12'h028; // hardware general call identifier
  localparam logic [11:0] CFG_OFF = 12'h02C; // serial_bus_configuration
  localparam logic [11:0] SADDR0_OFF = 12'h038; // slave_match_address_0
  localparam logic [11:0] SADDR1_OFF = 12'h03C; // slave_match_address_1
  localparam logic [11:0] SADDR2_OFF = 12'h040; // slave_match_address_2
  localparam logic [11:0] SADDR3_OFF = 12'h044; // slave_match_address_3
  localparam logic [11:0] GCSTAT_OFF = 12'h050; // general call status
  localparam logic [11:0] INTSTAT_OFF = 12'h054; // sticky interrupt status, read clears
  localparam logic [11:0] INTMASK_OFF = 12'h058; // interrupt mask, 1 lets a bit through
  // writable bits of the configuration word: 10, 2 and 31:11 stay zero
  localparam logic [31:0] CFG_WMASK = 32'h0000_03FB;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // configuration word layout, bit 0 last
  typedef struct packed {
    logic [20:0] rsvd_hi; // 31:11
    logic rsvd10; // 10
    logic txreq_dis; // 9, inverted sense
    logic gc_clr; // 8, self clearing
    logic mclk_en; // 7
    logic loopback; // 6
    logic backoff_dis; // 5
    logic hwgc_en; // 4
    logic gc_en; // 3
    logic rsvd2; // 2
    logic mst_en; // 1
    logic slv_en; // 0
  } i2ccfg_cfg_t;
  // general call status layout
  typedef struct packed {
    logic hw_call; // 3
    logic addr_cmd; // 2
    logic reset_cmd; // 1
    logic seen; // 0
  } i2ccfg_gcstat_t;
  // interrupt status / mask bit positions
  localparam int INT_TXREQ = 0;
  localparam int INT_GCALL = 1;
  localparam int INT_HWGC = 2;
  localparam int INT_W = 3;
  // bus protocol constants
  localparam logic [7:0] GC_ADDR = 8'h00; // general call write address byte
  localparam logic [7:0] GC_CMD_RESET = 8'h06;
  localparam logic [7:0] GC_CMD_ADDR = 8'h04;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // back-off after lost arbitration
  localparam int CLK_NS = 20;
  localparam int BACKOFF_NS = 5000;
  localparam logic [8:0] BACKOFF_CYC = 9'(BACKOFF_NS / CLK_NS);
  // slave receiver states
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK_A, S_DATA, S_ACK_D, S_XFER, S_SKIP} i2ccfg_st_t;
endpackage

// *** rtl/i2ccfg_top.sv ***
// configuration control, slave address/general call receiver and AXI4-Lite register file
`timescale 1ns/10ps
module i2ccfg_top
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic mst_scl_low,
  input wire logic mst_sda_low,
  input wire logic arb_lost,
  output logic mst_enable,
  output logic mst_scl_gen,
  output logic mst_retry,
  output logic slv_reset,
  output logic irq
);
  // register storage
  i2ccfg_pkg::i2ccfg_cfg_t cfg_r; // configuration word
  i2ccfg_pkg::i2ccfg_gcstat_t gcstat_r; // general call status
  logic [7:0] hwgc_id_r; // hardware general call identifier
  logic [7:0] saddr_r [4]; // slave match addresses, 7-bit address in bits 7:1
  logic [i2ccfg_pkg::INT_W-1:0] intstat_r; // sticky events
  logic [i2ccfg_pkg::INT_W-1:0] intmask_r; // enables
  // bus slave state
  logic [11:0] awaddr_r;
  logic aw_full_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_full_r;
  logic do_write; // both halves held and no response pending
  logic rd_take; // read address accepted this cycle
  logic [31:0] wmerged; // write data merged by byte lanes over the old value
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr_hit;
  // pin synchronisers and bus view
  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r; // first and second stage
  logic scl_bus, sda_bus; // level seen by the receiver
  logic scl_q_r, sda_q_r; // previous bus level
  logic scl_rise, scl_fall, start_cond, stop_cond;
  // receiver
  i2ccfg_pkg::i2ccfg_st_t st_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic is_gc_r; // current transfer is a general call
  logic addr_match; // address byte hits one of the four slave addresses
  logic ev_txreq, ev_gcall, ev_hwgc, ev_rst, ev_acmd;
  // back-off
  logic [8:0] backoff_cnt_r;

  // merge write data into the addressed register's current value by byte lane
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // bus slave: address and data are taken independently, in either order
  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;

  // write address / data capture and response
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= i2ccfg_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? i2ccfg_pkg::RESP_OKAY : i2ccfg_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        // ready again only once the response is gone: one write in flight
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write decode; status registers are not writable but answer OKAY
  always_comb
  begin
    wmerged = lane_merge(cfg_r, wdata_r, wstrb_r);
    if (awaddr_r == i2ccfg_pkg::CFG_OFF || awaddr_r == i2ccfg_pkg::HWGC_ID_OFF)
      wr_hit = 1'b1;
    else if (awaddr_r == i2ccfg_pkg::SADDR0_OFF || awaddr_r == i2ccfg_pkg::SADDR1_OFF)
      wr_hit = 1'b1;
    else if (awaddr_r == i2ccfg_pkg::SADDR2_OFF || awaddr_r == i2ccfg_pkg::SADDR3_OFF)
      wr_hit = 1'b1;
    else if (awaddr_r == i2ccfg_pkg::GCSTAT_OFF || awaddr_r == i2ccfg_pkg::INTSTAT_OFF)
      wr_hit = 1'b1;
    else if (awaddr_r == i2ccfg_pkg::INTMASK_OFF)
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  // configuration word: software writes, hardware self-clears bit 8, bus reset command clears all
  always_ff @(posedge sys_clk)
  begin
    if (srst || ev_rst)
    begin
      cfg_r <= i2ccfg_pkg::CFG_RESET;
    end
    else if (do_write && awaddr_r == i2ccfg_pkg::CFG_OFF)
    begin
      cfg_r <= wmerged & i2ccfg_pkg::CFG_WMASK;
    end
    else if (cfg_r.gc_clr)
    begin
      cfg_r.gc_clr <= 1'b0;
    end
  end

  // identifier, slave addresses and mask; lanes above the low byte are ignored
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hwgc_id_r <= i2ccfg_pkg::BYTE_RESET;
      intmask_r <= '0;
      for (int i = 0; i < 4; i++)
        saddr_r[i] <= i2ccfg_pkg::BYTE_RESET;
    end
    else if (do_write && wstrb_r[0])
    begin
      if (awaddr_r == i2ccfg_pkg::HWGC_ID_OFF)
        hwgc_id_r <= wdata_r[7:0];
      else if (awaddr_r == i2ccfg_pkg::SADDR0_OFF)
        saddr_r[0] <= wdata_r[7:0];
      else if (awaddr_r == i2ccfg_pkg::SADDR1_OFF)
        saddr_r[1] <= wdata_r[7:0];
      else if (awaddr_r == i2ccfg_pkg::SADDR2_OFF)
        saddr_r[2] <= wdata_r[7:0];
      else if (awaddr_r == i2ccfg_pkg::SADDR3_OFF)
        saddr_r[3] <= wdata_r[7:0];
      else if (awaddr_r == i2ccfg_pkg::INTMASK_OFF)
        intmask_r <= wdata_r[i2ccfg_pkg::INT_W-1:0];
    end
  end

  // read decode
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == i2ccfg_pkg::CFG_OFF)
      rd_val = cfg_r;
    else if (s_axi_araddr == i2ccfg_pkg::HWGC_ID_OFF)
      rd_val[7:0] = hwgc_id_r;
    else if (s_axi_araddr == i2ccfg_pkg::SADDR0_OFF)
      rd_val[7:0] = saddr_r[0];
    else if (s_axi_araddr == i2ccfg_pkg::SADDR1_OFF)
      rd_val[7:0] = saddr_r[1];
    else if (s_axi_araddr == i2ccfg_pkg::SADDR2_OFF)
      rd_val[7:0] = saddr_r[2];
    else if (s_axi_araddr == i2ccfg_pkg::SADDR3_OFF)
      rd_val[7:0] = saddr_r[3];
    else if (s_axi_araddr == i2ccfg_pkg::GCSTAT_OFF)
      rd_val[3:0] = gcstat_r;
    else if (s_axi_araddr == i2ccfg_pkg::INTSTAT_OFF)
      rd_val[i2ccfg_pkg::INT_W-1:0] = intstat_r;
    else if (s_axi_araddr == i2ccfg_pkg::INTMASK_OFF)
      rd_val[i2ccfg_pkg::INT_W-1:0] = intmask_r;
    else
      rd_hit = 1'b0;
  end

  // read channel: one read in flight, data one cycle after the address is taken
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= i2ccfg_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? i2ccfg_pkg::RESP_OKAY : i2ccfg_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // pin synchronisers: the first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      {scl_m_r, scl_s_r, sda_m_r, sda_s_r} <= 4'hF;
    end
    else
    begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
    end
  end

  // loopback hands the master's own drive to the receiver instead of the pins
  assign scl_bus = cfg_r.loopback ? !mst_scl_low : scl_s_r;
  assign sda_bus = cfg_r.loopback ? !mst_sda_low : sda_s_r;

  // previous bus level for edge and condition detection
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      {scl_q_r, sda_q_r} <= 2'h3;
    else
      {scl_q_r, sda_q_r} <= {scl_bus, sda_bus};
  end

  assign scl_rise = scl_bus && !scl_q_r;
  assign scl_fall = !scl_bus && scl_q_r;
  assign start_cond = scl_bus && scl_q_r && sda_q_r && !sda_bus;
  assign stop_cond = scl_bus && scl_q_r && !sda_q_r && sda_bus;

  // address match against the four slave addresses, only with the slave channel on
  always_comb
  begin
    addr_match = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (shift_r[7:1] == saddr_r[i][7:1])
        addr_match = cfg_r.slv_en;
    end
  end

  // events, each a one-cycle pulse on the falling edge that ends a byte or its acknowledge
  assign ev_txreq = scl_fall && st_r == i2ccfg_pkg::S_ADDR && bit_cnt_r == i2ccfg_pkg::BITS_PER_BYTE
                    && addr_match && shift_r[0] && !cfg_r.txreq_dis;
  assign ev_gcall = scl_fall && st_r == i2ccfg_pkg::S_DATA
                    && bit_cnt_r == i2ccfg_pkg::BITS_PER_BYTE;
  assign ev_hwgc = ev_gcall && cfg_r.hwgc_en && cfg_r.gc_en && shift_r == hwgc_id_r;
  assign ev_rst = scl_fall && st_r == i2ccfg_pkg::S_ACK_D
                  && shift_r == i2ccfg_pkg::GC_CMD_RESET;
  assign ev_acmd = ev_gcall && shift_r == i2ccfg_pkg::GC_CMD_ADDR;

  // receiver: address byte, acknowledge, optional general call data byte
  always_ff @(posedge sys_clk)
  begin
    if (srst || ev_rst)
    begin
      st_r <= i2ccfg_pkg::S_IDLE;
      shift_r <= i2ccfg_pkg::BYTE_RESET;
      bit_cnt_r <= 4'h0;
      is_gc_r <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (stop_cond)
    begin
      st_r <= i2ccfg_pkg::S_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_cond)
    begin
      // a repeated start also restarts address matching
      st_r <= i2ccfg_pkg::S_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (scl_rise && (st_r == i2ccfg_pkg::S_ADDR || st_r == i2ccfg_pkg::S_DATA)
             && bit_cnt_r != i2ccfg_pkg::BITS_PER_BYTE)
    begin
      shift_r <= {shift_r[6:0], sda_bus};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
    else if (scl_fall)
    begin
      case (st_r)
        i2ccfg_pkg::S_ADDR:
        begin
          if (bit_cnt_r == i2ccfg_pkg::BITS_PER_BYTE)
          begin
            is_gc_r <= shift_r == i2ccfg_pkg::GC_ADDR && cfg_r.gc_en && cfg_r.slv_en;
            if (addr_match || (shift_r == i2ccfg_pkg::GC_ADDR && cfg_r.gc_en && cfg_r.slv_en))
            begin
              st_r <= i2ccfg_pkg::S_ACK_A;
              sda_oe <= !cfg_r.loopback;
            end
            else
              st_r <= i2ccfg_pkg::S_SKIP;
          end
        end
        i2ccfg_pkg::S_ACK_A:
        begin
          sda_oe <= 1'b0;
          bit_cnt_r <= 4'h0;
          st_r <= is_gc_r ? i2ccfg_pkg::S_DATA : i2ccfg_pkg::S_XFER;
        end
        i2ccfg_pkg::S_DATA:
        begin
          if (bit_cnt_r == i2ccfg_pkg::BITS_PER_BYTE)
          begin
            st_r <= i2ccfg_pkg::S_ACK_D;
            sda_oe <= !cfg_r.loopback;
          end
        end
        i2ccfg_pkg::S_ACK_D:
        begin
          sda_oe <= 1'b0;
          st_r <= i2ccfg_pkg::S_XFER;
        end
        default:
        begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // general call status: set wins over the bit 8 clear
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      gcstat_r <= '0;
    else
    begin
      if (cfg_r.gc_clr)
        gcstat_r <= '0;
      if (ev_gcall)
        gcstat_r.seen <= 1'b1;
      if (ev_gcall && shift_r == i2ccfg_pkg::GC_CMD_RESET)
        gcstat_r.reset_cmd <= 1'b1;
      if (ev_acmd)
        gcstat_r.addr_cmd <= 1'b1;
      if (ev_hwgc)
        gcstat_r.hw_call <= 1'b1;
    end
  end

  // sticky interrupt status: a read clears, a same-cycle event survives
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      intstat_r <= '0;
    else
    begin
      if (rd_take && s_axi_araddr == i2ccfg_pkg::INTSTAT_OFF)
        intstat_r <= '0;
      if (ev_txreq)
        intstat_r[i2ccfg_pkg::INT_TXREQ] <= 1'b1;
      if (ev_gcall)
        intstat_r[i2ccfg_pkg::INT_GCALL] <= 1'b1;
      if (ev_hwgc)
        intstat_r[i2ccfg_pkg::INT_HWGC] <= 1'b1;
    end
  end

  // master side controls and back-off after lost arbitration
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      mst_enable <= 1'b0;
      mst_scl_gen <= 1'b0;
      mst_retry <= 1'b0;
      backoff_cnt_r <= 9'h000;
    end
    else
    begin
      mst_enable <= cfg_r.mst_en;
      mst_scl_gen <= cfg_r.mst_en && cfg_r.mclk_en;
      mst_retry <= 1'b0;
      if (arb_lost && cfg_r.mst_en)
      begin
        if (cfg_r.backoff_dis)
          mst_retry <= 1'b1;
        else
          backoff_cnt_r <= i2ccfg_pkg::BACKOFF_CYC;
      end
      else if (backoff_cnt_r != 9'h000)
      begin
        backoff_cnt_r <= backoff_cnt_r - 9'h001;
        mst_retry <= backoff_cnt_r == 9'h001 && cfg_r.mst_en;
      end
    end
  end

  // pin drive, bus reset pulse and interrupt line
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sda_o <= 1'b0;
      slv_reset <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0; // open drain: only the enable moves
      slv_reset <= ev_rst;
      irq <= |(intstat_r & intmask_r);
    end
  end

  // checks
  // suppressed request: a clear status bit must stay clear, whatever the receiver does
  AST_TXREQ_INV: assert property (@(posedge sys_clk) disable iff (srst)
    cfg_r.txreq_dis && !intstat_r[i2ccfg_pkg::INT_TXREQ] |=> !intstat_r[i2ccfg_pkg::INT_TXREQ])
    else $error("request raised while suppressed");
  AST_TXREQ_SET: assert property (@(posedge sys_clk) disable iff (srst)
    ev_txreq |=> intstat_r[i2ccfg_pkg::INT_TXREQ]) else $error("request not flagged");
  AST_GCCLR: assert property (@(posedge sys_clk) disable iff (srst)
    cfg_r.gc_clr && !ev_gcall && !(do_write && awaddr_r == i2ccfg_pkg::CFG_OFF)
    |=> gcstat_r == '0 && !cfg_r.gc_clr) else $error("call status clear failed");
  AST_SCLGEN: assert property (@(posedge sys_clk) disable iff (srst)
    !cfg_r.mclk_en |=> !mst_scl_gen) else $error("clock generation not stopped");
  AST_LOOP: assert property (@(posedge sys_clk) disable iff (srst)
    cfg_r.loopback && $stable(cfg_r.loopback) |-> !sda_oe) else $error("pin driven in loopback");
  AST_RETRY_NOW: assert property (@(posedge sys_clk) disable iff (srst)
    arb_lost && cfg_r.mst_en && cfg_r.backoff_dis |=> mst_retry) else $error("no retry");
  AST_RETRY_WAIT: assert property (@(posedge sys_clk) disable iff (srst)
    arb_lost && cfg_r.mst_en && !cfg_r.backoff_dis |=> !mst_retry [*8])
    else $error("retry without back-off");
  AST_HWGC: assert property (@(posedge sys_clk) disable iff (srst)
    ev_hwgc |=> gcstat_r.hw_call && intstat_r[i2ccfg_pkg::INT_HWGC])
    else $error("hardware call not flagged");
  AST_RESET: assert property (@(posedge sys_clk) disable iff (srst)
    ev_rst |=> slv_reset && cfg_r == i2ccfg_pkg::CFG_RESET) else $error("bus reset missed");
  AST_GCALL: assert property (@(posedge sys_clk) disable iff (srst)
    ev_gcall |=> gcstat_r.seen && intstat_r[i2ccfg_pkg::INT_GCALL])
    else $error("general call not flagged");
  AST_MSTEN: assert property (@(posedge sys_clk) disable iff (srst)
    mst_enable == $past(cfg_r.mst_en) || $past(srst)) else $error("master enable mismatch");
  AST_NOACK_OFF: assert property (@(posedge sys_clk) disable iff (srst)
    !cfg_r.slv_en && $stable(cfg_r.slv_en) && st_r == i2ccfg_pkg::S_ADDR
    |=> st_r != i2ccfg_pkg::S_ACK_A) else $error("acknowledge while disabled");
  AST_RSVD: assert property (@(posedge sys_clk) disable iff (srst)
    !cfg_r.rsvd10 && !cfg_r.rsvd2 && cfg_r.rsvd_hi == '0) else $error("reserved bit set");
endmodule

// *** test/i2ccfg_bus_model.sv ***
// behavioural two-wire bus master that drives the slave receiver
`timescale 1ns/10ps
module i2ccfg_bus_model
(
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  // both lines released (pulled high) between frames; scl stands still there
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // start condition: sda falls while scl is high
  task automatic start();
    // step off the sampling edge first, so no pin ever moves where it is sampled
    #5 sda_drv = 1'b0;
    #80 scl = 1'b0;
    #40;
  endtask
  // one byte msb first, then the acknowledge slot; ack is 1 when the slave pulls sda
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv = d[i];
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #40;
    end
    // release sda so only the slave can hold it low in the slot
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 ack = ~sda_line;
    #40 scl = 1'b0;
    #40;
  endtask
  // stop condition: sda rises while scl is high
  task automatic stop();
    sda_drv = 1'b0;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #80;
  endtask
endmodule

// *** test/tb.sv ***
// self-checking bench: register bus, slave receiver, general call and back-off
`timescale 1ns/10ps
module tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic arb_lost = 1'b0;
  logic lb = 1'b0; // loopback run: model drives the master inputs, pins held idle
  logic scl, sda_drv, sda_o, sda_oe, mst_enable, mst_scl_gen, mst_retry, slv_reset, irq, ack;
  int n_errors = 0, num_checks = 0, n_rst = 0, cyc = 0;
  // open-drain data line: low while either party pulls it
  wire sda_line = sda_drv & ~sda_oe;
  // clock of 20 ns
  always #10 sys_clk = ~sys_clk;
  // in the loopback run the pins idle high, so only the master inputs can carry a frame
  i2ccfg_top i2ccfg_top_inst (.sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl | lb),
    .sda_i(sda_line | lb), .sda_o(sda_o), .sda_oe(sda_oe), .mst_scl_low(lb & ~scl),
    .mst_sda_low(lb & ~sda_drv),
    .arb_lost(arb_lost), .mst_enable(mst_enable), .mst_scl_gen(mst_scl_gen),
    .mst_retry(mst_retry), .slv_reset(slv_reset), .irq(irq));
  i2ccfg_bus_model i2ccfg_bus_model_inst (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  // counts bus reset pulses
  always @(posedge sys_clk)
    if (slv_reset === 1'b1) n_rst++;
  // compare one result word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  // read and compare data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // lost arbitration pulse, then cycles until retry must fall in lo..hi
  task automatic arb(input int lo, input int hi);
    @(posedge sys_clk);
    arb_lost <= 1'b1;
    @(posedge sys_clk);
    arb_lost <= 1'b0;
    cyc = 0;
    while (mst_retry !== 1'b1 && cyc < 400)
    begin
      @(posedge sys_clk);
      cyc++;
    end
    chk(32'(cyc >= lo && cyc <= hi), 32'h1);
  endtask
  // one frame: address, optional data byte, expected acknowledges
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic two,
    input logic ea, input logic ed);
    i2ccfg_bus_model_inst.start();
    i2ccfg_bus_model_inst.send(a, ack);
    chk({31'h0, ack}, {31'h0, ea});
    if (two)
    begin
      i2ccfg_bus_model_inst.send(d, ack);
      chk({31'h0, ack}, {31'h0, ed});
    end
    i2ccfg_bus_model_inst.stop();
    repeat (4) @(posedge sys_clk);
  endtask
  // the single exit: counts, verdict, end
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog: the sequence needs well under 100 us
  initial
  begin
    #400000;
    n_errors++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    rd(i2ccfg_pkg::CFG_OFF, 32'h0, i2ccfg_pkg::RESP_OKAY);
    wr(i2ccfg_pkg::CFG_OFF, 32'hFFFF_FFFF, i2ccfg_pkg::RESP_OKAY);
    rd(i2ccfg_pkg::CFG_OFF, 32'h0000_02FB, i2ccfg_pkg::RESP_OKAY);
    chk({30'h0, mst_enable, mst_scl_gen}, 32'h3);
    arb(1, 3);
    wr(i2ccfg_pkg::CFG_OFF, 32'h0000_0082, i2ccfg_pkg::RESP_OKAY);
    arb(248, 253);
    wr(i2ccfg_pkg::CFG_OFF, 32'h0000_0080, i2ccfg_pkg::RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk({30'h0, mst_enable, mst_scl_gen}, 32'h0);
    arb(400, 400);
    rd(12'hFFC, 32'h0, i2ccfg_pkg::RESP_SLVERR);
    wr(12'hFFC, 32'h1, i2ccfg_pkg::RESP_SLVERR);
    wr(i2ccfg_pkg::HWGC_ID_OFF, 32'h35, i2ccfg_pkg::RESP_OKAY);
    wr(i2ccfg_pkg::SADDR0_OFF, 32'hA0, i2ccfg_pkg::RESP_OKAY);
    wr(i2ccfg_pkg::SADDR3_OFF, 32'hFFFF_FF5C, i2ccfg_pkg::RESP_OKAY);
    rd(i2ccfg_pkg::SADDR3_OFF, 32'h5C, i2ccfg_pkg::RESP_OKAY);
    wr(i2ccfg_pkg::INTMASK_OFF, 32'h7, i2ccfg_pkg::RESP_OKAY);
    wr(i2ccfg_pkg::CFG_OFF, 32'h19, i2ccfg_pkg::RESP_OKAY);
    frame(8'hA1, 8'h00, 1'b0, 1'b1, 1'b0);
    chk({31'h0, irq}, 32'h1);
    rd(i2ccfg_pkg::INTSTAT_OFF, 32'h1, i2ccfg_pkg::RESP_OKAY);
    rd(i2ccfg_pkg::INTSTAT_OFF, 32'h0, i2ccfg_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    frame(8'h5C, 8'h00, 1'b0, 1'b1, 1'b0);
    frame(8'hB0, 8'h00, 1'b1, 1'b0, 1'b0);
    frame(8'h00, 8'h04, 1'b1, 1'b1, 1'b1);
    rd(i2ccfg_pkg::GCSTAT_OFF, 32'h5, i2ccfg_pkg::RESP_OKAY);
    rd(i2ccfg_pkg::INTSTAT_OFF, 32'h2, i2ccfg_pkg::RESP_OKAY);
    wr(i2ccfg_pkg::CFG_OFF, 32'h119, i2ccfg_pkg::RESP_OKAY);
    rd(i2ccfg_pkg::GCSTAT_OFF, 32'h0, i2ccfg_pkg::RESP_OKAY);
    frame(8'h00, 8'h35, 1'b1, 1'b1, 1'b1);
    rd(i2ccfg_pkg::GCSTAT_OFF, 32'h9, i2ccfg_pkg::RESP_OKAY);
    rd(i2ccfg_pkg::INTSTAT_OFF, 32'h6, i2ccfg_pkg::RESP_OKAY);
    wr(i2ccfg_pkg::CFG_OFF, 32'h219, i2ccfg_pkg::RESP_OKAY);
    frame(8'hA1, 8'h00, 1'b0, 1'b1, 1'b0);
    rd(i2ccfg_pkg::INTSTAT_OFF, 32'h0, i2ccfg_pkg::RESP_OKAY);
    wr(i2ccfg_pkg::INTMASK_OFF, 32'h0, i2ccfg_pkg::RESP_OKAY);
    frame(8'h00, 8'h11, 1'b1, 1'b1, 1'b1);
    chk({31'h0, irq}, 32'h0);
    frame(8'h00, 8'h06, 1'b1, 1'b1, 1'b1);
    chk(n_rst, 32'h1);
    rd(i2ccfg_pkg::CFG_OFF, 32'h0, i2ccfg_pkg::RESP_OKAY);
    frame(8'hA1, 8'h00, 1'b0, 1'b0, 1'b0);
    rd(i2ccfg_pkg::INTSTAT_OFF, 32'h2, i2ccfg_pkg::RESP_OKAY);
    wr(i2ccfg_pkg::CFG_OFF, 32'h49, i2ccfg_pkg::RESP_OKAY);
    lb <= 1'b1;
    frame(8'h00, 8'h11, 1'b1, 1'b0, 1'b0);
    rd(i2ccfg_pkg::INTSTAT_OFF, 32'h2, i2ccfg_pkg::RESP_OKAY);
    print_verdict();
  end
endmodule
